// File: include/npf_regs.vh
`ifndef NPF_REGS_VH
`define NPF_REGS_VH
// register byte offsets
`define NPF_CTRL_OFF      12'h000
`define NPF_CFG_OFF       12'h004
`define NPF_STAT_OFF      12'h008
`define NPF_IRQ_STAT_OFF  12'h00C
`define NPF_IRQ_MASK_OFF  12'h010
`define NPF_TXLEN_OFF     12'h014
`define NPF_TXDATA_OFF    12'h018
`define NPF_RXDATA_OFF    12'h01C
`define NPF_RXLEN_OFF     12'h020
// ctrl bits (write one to issue)
`define NPF_CTRL_SEND     0
`define NPF_CTRL_RECV     1
// cfg fields
`define NPF_CFG_CNT_LSB   0
`define NPF_CFG_START_LSB 8
`define NPF_CFG_END_LSB   16
`define NPF_CFG_START_EN  24
`define NPF_CFG_MODE_LSB  28
`define NPF_CFG_RESET     32'h00000000
// end modes
`define NPF_MODE_COUNT    2'h0
`define NPF_MODE_ENDB     2'h1
`define NPF_MODE_CRLF     2'h2
// status bit positions (also irq bits)
`define NPF_ST_TXRDY      0
`define NPF_ST_RXDONE     1
// limits
`define NPF_MAX_PAYLOAD   9'h100
`define NPF_MAX_FRAME     9'h103
`define NPF_CR            8'h0D
`define NPF_LF            8'h0A
`endif

// File: hw/npf_buf.v
`timescale 1ns/10ps
`default_nettype none
// payload store, one write and one read port
module npf_buf #(
    parameter DEPTH = 256,
    parameter AW    = 8
) (
    input  wire          clock,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [7:0]    wdata,
    input  wire [AW-1:0] raddr,
    output reg  [7:0]    rdata_q
);
    reg [7:0] mem [0:DEPTH-1];

    // registered read and write
    always @(posedge clock)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata_q <= mem[raddr];
    end
endmodule // npf_buf
`default_nettype wire

// File: hw/npf_framer.v
`timescale 1ns/10ps
`default_nettype none
`include "npf_regs.vh"
// How it works
// - whole frame at most 259 bytes
// - payload 256 max, optional delimiters around
// - received delimiters are dropped, payload kept
// - start delimiter and end byte or crlf are both effective
// - tx ready low while sending, high after
// - rx done set when frame complete
// - receive command while rx done is set restarts the hunt, clears rx done
// - two status flags, tx ready and rx done
// - start delimiter gates payload collection
// - end on delimiter, count or 256 bytes
// - mode 0 count, 1 end byte, 2 crlf
// - count 00 means 256, else 1..255
module npf_framer (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        irq,
    output reg  [7:0]  tx_byte_q,
    output reg         tx_valid_q,
    input  wire        tx_ready,
    input  wire [7:0]  rx_byte,
    input  wire        rx_valid
);
    localparam TX_IDLE  = 2'h0;
    localparam TX_START = 2'h1;
    localparam TX_DATA  = 2'h2;
    localparam TX_END   = 2'h3;
    localparam RX_HUNT  = 2'h0;
    localparam RX_DATA  = 2'h1;
    localparam RX_HELD  = 2'h2;

    reg [31:0] cfg_q;
    reg [1:0]  irq_stat_q;
    reg [1:0]  irq_mask_q;
    reg [8:0]  txlen_q;
    reg [7:0]  txmem [0:255];
    reg [1:0]  tx_st_q;
    reg [8:0]  tx_idx_q;
    reg        tx_crlf_q;
    reg [1:0]  rx_st_q;
    reg [8:0]  rx_cnt_q;
    reg [8:0]  rx_len_q;
    reg        cr_seen_q;
    reg        rx_done_q;
    reg [7:0]  rd_idx_q;
    reg [7:0]  out_data_q;
    reg        out_valid_q;
    wire [7:0] buf_rdata;

    // cfg fields
    wire [7:0] cfg_cnt   = cfg_q[`NPF_CFG_CNT_LSB +: 8];
    wire [7:0] cfg_start = cfg_q[`NPF_CFG_START_LSB +: 8];
    wire [7:0] cfg_end   = cfg_q[`NPF_CFG_END_LSB +: 8];
    wire       start_en  = cfg_q[`NPF_CFG_START_EN];
    wire [1:0] end_mode  = cfg_q[`NPF_CFG_MODE_LSB +: 2];

    // apb decode
    wire wr_acc = psel & penable & pwrite;
    wire rd_acc = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    wire send_cmd = wr_acc & hit(paddr, `NPF_CTRL_OFF)
                    & pwdata[`NPF_CTRL_SEND];
    wire recv_cmd = wr_acc & hit(paddr, `NPF_CTRL_OFF)
                    & pwdata[`NPF_CTRL_RECV];
    wire tx_rdy = (tx_st_q == TX_IDLE);
    // settings are frozen while a frame is being sent
    wire cfg_wr = wr_acc & tx_rdy & hit(paddr, `NPF_CFG_OFF);

    // count setting: 00 means 256
    wire [8:0] cnt_lim = (cfg_cnt == 8'h00) ? `NPF_MAX_PAYLOAD
                                           : {1'b0, cfg_cnt};

    // configuration and transmit staging registers
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            cfg_q      <= `NPF_CFG_RESET;
            irq_mask_q <= 2'h0;
            txlen_q    <= 9'h000;
        end
        else
        begin
            if (cfg_wr)
                cfg_q <= pwdata;
            if (wr_acc && tx_rdy && hit(paddr, `NPF_TXLEN_OFF))
                txlen_q <= (pwdata[8:0] > `NPF_MAX_PAYLOAD) ?
                           `NPF_MAX_PAYLOAD : pwdata[8:0];
            if (wr_acc && hit(paddr, `NPF_IRQ_MASK_OFF))
                irq_mask_q <= pwdata[1:0]; // mask stays writable
        end
    end

    // payload for transmit written by index in bits 15:8
    always @(posedge clock)
    begin
        if (wr_acc && tx_rdy && hit(paddr, `NPF_TXDATA_OFF))
            txmem[pwdata[15:8]] <= pwdata[7:0];
    end

    // transmit sequencer: start byte, payload, end byte or cr lf
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            tx_st_q    <= TX_IDLE;
            tx_idx_q   <= 9'h000;
            tx_valid_q <= 1'b0;
            tx_byte_q  <= 8'h00;
            tx_crlf_q  <= 1'b0;
        end
        else if (tx_valid_q && !tx_ready)
            tx_st_q <= tx_st_q; // hold byte until taken
        else
        begin
            tx_valid_q <= 1'b0;
            case (tx_st_q)
            TX_IDLE:
                if (send_cmd)
                begin
                    tx_idx_q  <= 9'h000;
                    tx_crlf_q <= 1'b0;
                    if (start_en)
                    begin
                        tx_byte_q  <= cfg_start;
                        tx_valid_q <= 1'b1;
                    end
                    tx_st_q <= TX_DATA;
                end
            TX_DATA:
                if (tx_idx_q < txlen_q)
                begin
                    tx_byte_q  <= txmem[tx_idx_q[7:0]];
                    tx_valid_q <= 1'b1;
                    tx_idx_q   <= tx_idx_q + 9'h001;
                end
                else
                    tx_st_q <= TX_END;
            TX_END:
                if (end_mode == `NPF_MODE_ENDB)
                begin
                    tx_byte_q  <= cfg_end;
                    tx_valid_q <= 1'b1;
                    tx_st_q    <= TX_START;
                end
                else if (end_mode == `NPF_MODE_CRLF && !tx_crlf_q)
                begin
                    tx_byte_q  <= `NPF_CR;
                    tx_valid_q <= 1'b1;
                    tx_crlf_q  <= 1'b1;
                end
                else if (end_mode == `NPF_MODE_CRLF)
                begin
                    tx_byte_q  <= `NPF_LF;
                    tx_valid_q <= 1'b1;
                    tx_st_q    <= TX_START;
                end
                else
                    tx_st_q <= TX_START; // count mode: no end byte
            TX_START:
                tx_st_q <= TX_IDLE; // last byte taken, ready again
            default:
                tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // receive frame detection; a cr waits one slot past the count
    wire in_data  = (rx_st_q == RX_DATA);
    wire is_end   = (end_mode == `NPF_MODE_ENDB) && (rx_byte == cfg_end);
    wire crlf_end = cr_seen_q && (end_mode == `NPF_MODE_CRLF)
                    && (rx_byte == `NPF_LF);
    wire flush_cr = cr_seen_q && !crlf_end; // lone cr was payload
    wire [8:0] wr_pos = rx_cnt_q + {8'h00, flush_cr};
    // a cr in the last slot cannot wait, it counts as payload
    wire is_cr    = (end_mode == `NPF_MODE_CRLF) && (rx_byte == `NPF_CR)
                    && (wr_pos < 9'h0FF);
    wire store    = rx_valid && in_data && !is_end && !crlf_end && !is_cr;
    wire [8:0] cnt_after = rx_cnt_q + {8'h00, flush_cr}
                           + {8'h00, store};
    wire hit_limit = (cnt_after >= `NPF_MAX_PAYLOAD) ||
                     ((end_mode == `NPF_MODE_COUNT) &&
                      (cnt_after >= cnt_lim));
    wire rx_restart = cfg_wr && in_data;
    wire buf_we   = rx_valid && in_data && !is_end && !crlf_end;

    // receive state machine
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            rx_st_q   <= RX_HUNT;
            rx_cnt_q  <= 9'h000;
            rx_len_q  <= 9'h000;
            cr_seen_q <= 1'b0;
            rx_done_q <= 1'b0;
        end
        else if (rx_restart)
            rx_st_q <= RX_HUNT; // new settings restart the hunt
        else
            case (rx_st_q)
            RX_HUNT:
                begin
                    rx_cnt_q  <= 9'h000;
                    cr_seen_q <= 1'b0;
                    if (!start_en)
                        rx_st_q <= RX_DATA;
                    else if (rx_valid && rx_byte == cfg_start)
                        rx_st_q <= RX_DATA;
                end
            RX_DATA:
                if (rx_valid)
                begin
                    rx_cnt_q  <= cnt_after;
                    cr_seen_q <= is_cr;
                    if (is_end || crlf_end || hit_limit)
                    begin
                        rx_len_q  <= cnt_after;
                        rx_done_q <= 1'b1;
                        rx_st_q   <= RX_HELD;
                    end
                end
            RX_HELD:
                if (recv_cmd)
                begin
                    rx_done_q <= 1'b0;
                    rx_st_q   <= RX_HUNT;
                end
            default:
                rx_st_q <= RX_HUNT;
            endcase
    end

    // payload store; a parked cr is kept as payload or dropped by the count
    npf_buf #(.DEPTH(256), .AW(8)) u_buf (
        .clock   (clock),
        .we      (buf_we),
        .waddr   (wr_pos[7:0]),
        .wdata   (rx_byte),
        .raddr   (rd_idx_q),
        .rdata_q (buf_rdata)
    );

    // copy-out: each rxdata read returns next payload byte
    always @(posedge clock)
    begin
        if (!rst_n)
            rd_idx_q <= 8'h00;
        else if (recv_cmd || rx_st_q != RX_HELD)
            rd_idx_q <= 8'h00;
        else if (rd_acc && hit(paddr, `NPF_RXDATA_OFF))
            rd_idx_q <= rd_idx_q + 8'h01;
    end

    // sticky events, set wins over write-one clear
    wire tx_done_ev = (tx_st_q == TX_START) && !(tx_valid_q && !tx_ready);
    wire rx_done_ev = rx_valid && in_data && !rx_restart
                      && (is_end || crlf_end || hit_limit);
    always @(posedge clock)
    begin
        if (!rst_n)
            irq_stat_q <= 2'h0;
        else
        begin
            if (wr_acc && hit(paddr, `NPF_IRQ_STAT_OFF))
                irq_stat_q <= irq_stat_q & ~pwdata[1:0]
                              | {rx_done_ev, tx_done_ev};
            else
                irq_stat_q <= irq_stat_q | {rx_done_ev, tx_done_ev};
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // read mux
    always @*
    begin
        prdata = 32'h00000000;
        case (paddr)
        `NPF_CFG_OFF:      prdata = cfg_q;
        `NPF_STAT_OFF:     prdata = {30'h0, rx_done_q, tx_rdy};
        `NPF_IRQ_STAT_OFF: prdata = {30'h0, irq_stat_q};
        `NPF_IRQ_MASK_OFF: prdata = {30'h0, irq_mask_q};
        `NPF_TXLEN_OFF:    prdata = {23'h0, txlen_q};
        `NPF_RXDATA_OFF:   prdata = {24'h0, buf_rdata};
        `NPF_RXLEN_OFF:    prdata = {23'h0, rx_len_q};
        default:           prdata = 32'h00000000;
        endcase
    end
endmodule // npf_framer
`default_nettype wire

// File: testbench/npf_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "npf_regs.vh"
module npf_chk (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic [7:0]  tx_byte_q,
    input wire logic        tx_valid_q,
    input wire logic        tx_ready,
    input wire logic [7:0]  rx_byte,
    input wire logic        rx_valid
);
    logic [1:0] mask_q;
    logic [9:0] cnt_q;
    wire        wr_acc = psel && penable && pwrite;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // shadow of the mask and count of bytes sent since the last send
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            mask_q <= 2'h0;
        else if (wr_acc && paddr == `NPF_IRQ_MASK_OFF)
            mask_q <= pwdata[1:0];
        if (!rst_n)
            cnt_q <= 10'h000;
        else if (wr_acc && paddr == `NPF_CTRL_OFF && pwdata[0])
            cnt_q <= 10'h000;
        else if (tx_valid_q && tx_ready)
            cnt_q <= cnt_q + 10'h001;
    end
    // status read in its access phase
    sequence s_stat_rd;
        psel && penable && !pwrite && paddr == `NPF_STAT_OFF;
    endsequence
    AST_RESET: assert property (
        disable iff (1'b0) !rst_n |=> !tx_valid_q && !irq)
        else $error("outputs not cleared by reset");
    AST_TXHOLD: assert property (
        tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_byte_q))
        else $error("tx byte dropped before taken");
    AST_FRAME259: assert property (cnt_q <= 10'd259)
        else $error("frame longer than 259 bytes");
    AST_STAT_BUSY: assert property (
        s_stat_rd ##0 tx_valid_q |-> !prdata[0])
        else $error("tx ready shown while sending");
    AST_STAT_IDLE: assert property (
        s_stat_rd ##0 prdata[0] |-> !tx_valid_q)
        else $error("byte pending while tx ready");
    AST_STAT_RSV: assert property (
        s_stat_rd |-> prdata[31:2] == 30'h0)
        else $error("status spare bits set");
    AST_UNMAPPED: assert property (
        psel && penable && !pwrite && paddr == 12'h024 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_IRQ_MASK: assert property (mask_q == 2'h0 |-> !irq)
        else $error("irq with all masked");
    AST_NO_ERR: assert property (psel && penable |-> !pslverr)
        else $error("slave error raised");
endmodule // npf_chk
`default_nettype wire

// File: testbench/npf_remote.sv
`timescale 1ns/10ps
`default_nettype none
module npf_remote (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    output var  logic       tx_ready
);
    logic [7:0] cap [0:258];
    int         cap_n;
    // serializer that stalls every other cycle and keeps what it takes
    always @(posedge clock)
    begin
        if (!rst_n) tx_ready <= 1'b0;
        else tx_ready <= ~tx_ready;
        if (!rst_n) cap_n <= 0;
        else if (tx_valid && tx_ready && cap_n < 259)
        begin
            cap[cap_n] <= tx_byte;
            cap_n <= cap_n + 1;
        end
    end
endmodule // npf_remote
`default_nettype wire

// File: testbench/test_no_protocol_serial_framer.sv
`timescale 1ns/10ps
`default_nettype none
`include "npf_regs.vh"
module test_no_protocol_serial_framer;
    logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        rx_valid = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [7:0]  rx_byte = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, tx_valid_q, tx_ready;
    wire  [7:0]  tx_byte_q;
    int          failures = 0, cmp_count = 0, b0;
    always #10 clock = ~clock;
    npf_framer dut (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
        .rx_byte(rx_byte), .rx_valid(rx_valid));
    npf_remote rm (.clock(clock), .rst_n(rst_n), .tx_byte(tx_byte_q),
        .tx_valid(tx_valid_q), .tx_ready(tx_ready));
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one apb transfer, read data taken at the pready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        t = 0;
        do @(posedge clock); while (pready !== 1'b1 && ++t < 50);
        if (t >= 50) failures++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rx_put(input logic [7:0] b);
        @(posedge clock);
        rx_byte <= b;
        rx_valid <= 1'b1;
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
    // load n payload bytes 30h.., send, wait for tx ready
    task tx_run(input logic [31:0] cfg, input int n);
        int t;
        b0 = rm.cap_n;
        apb(1, `NPF_CFG_OFF, cfg);
        apb(1, `NPF_TXLEN_OFF, n);
        for (t = 0; t < n; t++)
            apb(1, `NPF_TXDATA_OFF, {t[7:0], 8'h30 + t[7:0]});
        apb(0, `NPF_STAT_OFF, 0);
        check("ready before send", rd[0], 1'b1);
        apb(1, `NPF_CTRL_OFF, 32'h1);
        apb(0, `NPF_STAT_OFF, 0);
        check("ready while sending", rd[0], 1'b0);
        t = 0;
        do
        begin
            apb(0, `NPF_STAT_OFF, 0);
            t++;
        end
        while (rd[0] !== 1'b1 && t < 200);
        check("ready after frame", rd[0], 1'b1);
    endtask
    task t_reset;
        apb(0, `NPF_STAT_OFF, 0);
        check("stat reset", rd, 32'h1);
        apb(0, `NPF_CFG_OFF, 0);
        check("cfg reset", rd, `NPF_CFG_RESET);
        apb(0, 12'h024, 0);
        check("unmapped", rd, 32'h0);
    endtask
    task t_tx_endbyte;
        apb(1, `NPF_IRQ_MASK_OFF, 32'h1);
        tx_run(32'h117EA500, 3);
        check("tx count", rm.cap_n - b0, 5);
        check("tx start", rm.cap[b0], 8'hA5);
        check("tx pay", rm.cap[b0 + 2], 8'h31);
        check("tx end", rm.cap[b0 + 4], 8'h7E);
        check("irq tx", irq, 1'b1);
        apb(1, `NPF_IRQ_STAT_OFF, 32'h1);
        // the clear lands at the access edge, look one edge later
        @(posedge clock);
        check("irq cleared", irq, 1'b0);
        apb(1, `NPF_IRQ_MASK_OFF, 32'h0);
    endtask
    task t_tx_crlf;
        tx_run(32'h20000000, 2);
        check("crlf count", rm.cap_n - b0, 4);
        check("crlf pay", rm.cap[b0], 8'h30);
        check("crlf cr", rm.cap[b0 + 2], `NPF_CR);
        check("crlf lf", rm.cap[b0 + 3], `NPF_LF);
    endtask
    // junk, start byte, A CR B CR LF: payload A CR B
    task t_rx_crlf;
        logic [63:0] s;
        int i;
        s = 64'h11225A410D420D0A;
        apb(1, `NPF_CFG_OFF, 32'h21005A00);
        apb(1, `NPF_IRQ_MASK_OFF, 32'h2);
        for (i = 0; i < 8; i++)
            rx_put(s[63 - 8 * i -: 8]);
        apb(0, `NPF_STAT_OFF, 0);
        check("rx done", rd[1], 1'b1);
        check("irq rx", irq, 1'b1);
        apb(0, `NPF_RXLEN_OFF, 0);
        check("rx len", rd, 32'h3);
        for (i = 0; i < 3; i++)
        begin
            apb(0, `NPF_RXDATA_OFF, 0);
            check("rx byte", rd[7:0], s[39 - 8 * i -: 8]);
        end
        apb(1, `NPF_IRQ_STAT_OFF, 32'h2);
        apb(1, `NPF_IRQ_MASK_OFF, 32'h0);
        apb(1, `NPF_CTRL_OFF, 32'h2);
        apb(0, `NPF_STAT_OFF, 0);
        check("rx done clear", rd[1], 1'b0);
    endtask
    // count 00 means 256, count 3 means 3, extra bytes ignored
    task t_rx_count;
        int k, i, n;
        for (k = 0; k < 2; k++)
        begin
            n = k ? 3 : 256;
            apb(1, `NPF_CFG_OFF, k ? 32'h3 : 32'h0);
            for (i = 0; i < n + 2; i++)
                rx_put(i[7:0] + 8'h01);
            apb(0, `NPF_RXLEN_OFF, 0);
            check("count len", rd, n);
            apb(0, `NPF_RXDATA_OFF, 0);
            check("count byte0", rd[7:0], 8'h01);
            apb(1, `NPF_CTRL_OFF, 32'h2);
            apb(0, `NPF_STAT_OFF, 0);
            check("count clear", rd[1], 1'b0);
        end
    endtask
    // no delimiters on send, end-byte mode on receive
    task t_plain;
        apb(1, `NPF_IRQ_STAT_OFF, 32'h3);
        tx_run(32'h00000000, 2);
        check("plain count", rm.cap_n - b0, 2);
        apb(0, `NPF_IRQ_STAT_OFF, 0);
        check("plain tx event", rd[0], 1'b1);
        apb(1, `NPF_CFG_OFF, 32'h107E0000);
        rx_put(8'h41);
        rx_put(8'h7E);
        rx_put(8'h42);
        apb(0, `NPF_RXLEN_OFF, 0);
        check("endb len", rd, 32'h1);
        apb(0, `NPF_RXDATA_OFF, 0);
        check("endb byte", rd[7:0], 8'h41);
        apb(1, `NPF_CTRL_OFF, 32'h2);
        apb(0, `NPF_STAT_OFF, 0);
        check("endb clear", rd[1], 1'b0);
    endtask
    initial
    begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_tx_endbyte;
        t_tx_crlf;
        t_rx_crlf;
        t_rx_count;
        t_plain;
        tally_and_finish;
    end
    initial
    begin
        #1500000;
        failures++;
        tally_and_finish;
    end
endmodule // test_no_protocol_serial_framer
bind npf_framer npf_chk chk (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
    .rx_byte(rx_byte), .rx_valid(rx_valid));
`default_nettype wire
